/* dv/cam_addr_decoder_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Decoder port checker
// ----------------------------------------------------------------
module cam_addr_decoder_sva
(
  input wire        clk_sys,
  input wire        nrst,
  input wire        fetchStart,
  input wire [15:0] pcStart,
  input wire        memAck,
  input wire        memRd,
  input wire [15:0] memAddr,
  input wire        busy,
  input wire        done,
  input wire [7:0]  opcode,
  input wire [3:0]  modeOut,
  input wire        useSecondIndex,
  input wire        immValid,
  input wire [15:0] effAddr,
  input wire [15:0] nextPc,
  input wire [2:0]  instrLen,
  input wire        swInterrupt,
  input wire        waitEntry,
  input wire        haltEntry,
  input wire        prefixIgnored,
  input wire        illegalReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Start address of the decode in flight, for the length check
  reg [15:0] pcCap_reg;
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
      pcCap_reg <= 16'h0000;
    else if (fetchStart && !busy)
      pcCap_reg <= pcStart;

  a_start_read: assert property (fetchStart && !busy |=>
    memRd && busy && memAddr == $past(pcStart)) else $error("first read not at start address");
  a_read_hold: assert property (memRd && !memAck |=> memRd && $stable(memAddr))
    else $error("read request dropped before ack");
  a_len_pc: assert property (done |-> nextPc == pcCap_reg + {13'h0000, instrLen})
    else $error("next address does not match length");
  a_len_range: assert property (done |-> instrLen >= 3'd1 && instrLen <= 3'd4)
    else $error("instruction length out of range");
  a_inh_len: assert property (done && modeOut == 4'h0 &&
    !useSecondIndex && !prefixIgnored |-> instrLen == 3'd1) else $error("inherent not one byte");
  a_imm_flag: assert property (done |-> immValid == (modeOut == 4'h1))
    else $error("immediate flag wrong");
  a_dir_page: assert property (done && modeOut == 4'h2 |->
    effAddr[15:8] == 8'h00) else $error("short direct beyond page zero");
  a_idx0_page: assert property (done && modeOut == 4'h4 |-> effAddr[15:8] == 8'h00)
    else $error("zero offset index beyond page zero");
  a_idx_short: assert property (done && modeOut == 4'h5 |->
    effAddr <= 16'h01fe) else $error("short indexed beyond 1fe");
  a_long_ops: assert property (done && (modeOut == 4'h3 || modeOut == 4'h6)
    |-> opcode[3:0] < 4'ha) else $error("long form on short-only op");
  a_rel_reach: assert property (done && modeOut == 4'h7
    |-> (effAddr - nextPc + 16'h0080) < 16'h0100) else $error("branch reach wrong");
  a_event_done: assert property (swInterrupt || waitEntry || haltEntry
    |-> done && modeOut == 4'h0) else $error("event pulse without inherent done");
  a_ill_idle: assert property (illegalReset |-> !done ##1 (!busy && !done))
    else $error("illegal code not back to idle");
endmodule // cam_addr_decoder_sva

bind cam_addr_decoder cam_addr_decoder_sva u_sva (.clk_sys(clk_sys), .nrst(nrst),
  .fetchStart(fetchStart), .pcStart(pcStart), .memAck(memAck), .memRd(memRd),
  .memAddr(memAddr), .busy(busy), .done(done), .opcode(opcode), .modeOut(modeOut),
  .useSecondIndex(useSecondIndex), .immValid(immValid), .effAddr(effAddr),
  .nextPc(nextPc), .instrLen(instrLen), .swInterrupt(swInterrupt),
  .waitEntry(waitEntry), .haltEntry(haltEntry), .prefixIgnored(prefixIgnored),
  .illegalReset(illegalReset));

/* dv/cam_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Program and data memory seen by the decoder
// ----------------------------------------------------------------
module cam_mem_model
(
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        memRd,
  input  wire [15:0] memAddr,
  input  wire [1:0]  stallMax,
  output logic       memAck,
  output logic [7:0] memRdata
);
  logic [7:0]  mem [0:65535];
  int unsigned waitCnt;

  // One ack per request; data toggles outside acks so stale bytes never match
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      memAck   <= 1'b0;
      memRdata <= 8'h00;
      waitCnt  <= 0;
    end
    else
    begin
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      if (memRd && !memAck)
      begin
        if (waitCnt == 0)
        begin
          memAck   <= 1'b1;
          memRdata <= mem[memAddr];
          waitCnt  <= $urandom_range(stallMax, 0);
        end
        else
          waitCnt <= waitCnt - 1;
      end
    end
endmodule // cam_mem_model

/* dv/test_cpu_addressing_mode_decoder.sv */
`timescale 1ns/1ps
module test_cpu_addressing_mode_decoder;
  typedef struct {
    logic ill; logic ce; logic [15:0] eff; logic [15:0] npc; logic [2:0] len;
    logic [3:0] mode; logic sec; logic ptr; logic [2:0] pul; logic pfx;
    logic imm; logic [7:0] opd;
  } cam_exp_t;

  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        fetchStart = 1'b0;
  logic [15:0] pcStart = 16'h0000;
  logic [7:0]  idxX = 8'h00;
  logic [7:0]  idxY = 8'h00;
  logic [1:0]  stallMax = 2'h0;
  wire         memAck, memRd, busy, done, useSecondIndex, viaPointer, immValid;
  wire         swInterrupt, waitEntry, haltEntry, prefixIgnored, illegalReset;
  wire [7:0]   memRdata, opcode, operand;
  wire [15:0]  memAddr, effAddr, nextPc;
  wire [3:0]   modeOut, opGroup;
  wire [2:0]   instrLen;
  int          failures = 0;
  int          checked = 0;
  cam_exp_t    expQ[$];

  always #12.5 clk_sys = ~clk_sys;

  cam_addr_decoder dut (.clk_sys(clk_sys), .nrst(nrst), .fetchStart(fetchStart),
    .pcStart(pcStart), .idxX(idxX), .idxY(idxY), .memRdata(memRdata), .memAck(memAck),
    .memRd(memRd), .memAddr(memAddr), .busy(busy), .done(done), .opcode(opcode),
    .modeOut(modeOut), .opGroup(opGroup), .useSecondIndex(useSecondIndex),
    .viaPointer(viaPointer), .immValid(immValid), .operand(operand), .effAddr(effAddr),
    .nextPc(nextPc), .instrLen(instrLen), .swInterrupt(swInterrupt),
    .waitEntry(waitEntry), .haltEntry(haltEntry), .prefixIgnored(prefixIgnored),
    .illegalReset(illegalReset));
  cam_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .memRd(memRd), .memAddr(memAddr),
    .stallMax(stallMax), .memAck(memAck), .memRdata(memRdata));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk1(input string what, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task pk(input logic [15:0] a, input logic [7:0] d0, d1, d2);
    u_mem.mem[a] = d0;
    u_mem.mem[a + 16'h1] = d1;
    u_mem.mem[a + 16'h2] = d2;
  endtask

  function automatic cam_exp_t mk(input logic [15:0] eff, input logic [15:0] npc,
    input logic [2:0] len, input logic [3:0] mode, input logic sec, input logic ptr);
    cam_exp_t e;
    e = '{default: '0};
    e.ce = 1'b1;
    e.eff = eff;
    e.npc = npc;
    e.len = len;
    e.mode = mode;
    e.sec = sec;
    e.ptr = ptr;
    return e;
  endfunction

  // Note the expectation, start one decode, wait bounded for its end
  task run(input logic [15:0] pc, input cam_exp_t e);
    int i;
    expQ.push_back(e);
    @(posedge clk_sys);
    fetchStart <= 1'b1;
    pcStart    <= pc;
    stallMax   <= 2'($urandom_range(2, 0));
    @(posedge clk_sys);
    fetchStart <= 1'b0;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (done === 1'b1 || illegalReset === 1'b1)
        break;
    end
    if (i == 300)
    begin
      failures++;
      $display("ERROR done expected 1 seen 0");
      end_of_test;
    end
  endtask

  // ----------------------------------------------------------------
  // Result monitor: oldest note against each completed decode
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
    if (nrst === 1'b1 && (done === 1'b1 || illegalReset === 1'b1))
    begin : mon
      cam_exp_t e;
      if (expQ.size() == 0)
        chk1("unexpected result", 1'b0, 1'b1);
      else
      begin
        e = expQ.pop_front();
        chk1("illegalReset", e.ill, illegalReset);
        if (!e.ill)
        begin
          if (e.ce) chk16("effAddr", e.eff, effAddr);
          chk16("nextPc", e.npc, nextPc);
          chk16("instrLen", {13'h0, e.len}, {13'h0, instrLen});
          chk16("modeOut", {12'h0, e.mode}, {12'h0, modeOut});
          chk1("opGroup", 1'b1, opGroup < 4'd13);
          chk1("useSecondIndex", e.sec, useSecondIndex);
          chk1("viaPointer", e.ptr, viaPointer);
          chk16("pulses", 16'(e.pul), 16'({swInterrupt, waitEntry, haltEntry}));
          chk1("prefixIgnored", e.pfx, prefixIgnored);
          chk1("immValid", e.imm, immValid);
          if (e.imm) chk16("operand", {8'h00, e.opd}, {8'h00, operand});
        end
      end
    end

  // ----------------------------------------------------------------
  // Main sequence; code at 1000, pointers in page zero
  // ----------------------------------------------------------------
  initial
  begin
    cam_exp_t e;
    int k;
    logic [7:0] r, r2, yv;
    k = $urandom(32'h255efa57);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    yv = 8'($urandom);
    r = 8'($urandom);
    r2 = 8'($urandom);
    idxX <= 8'hff;
    idxY <= yv;
    for (k = 0; k < 4; k++)
    begin
      pk(16'h1000, 8'(k), r, r2);
      e = mk(16'h0, 16'h1001, 3'd1, 4'h0, 1'b0, 1'b0);
      e.ce = 1'b0;
      e.pul = (k == 0) ? 3'b000 : 3'(3'b100 >> (k - 1));
      run(16'h1000, e);
    end
    pk(16'h1000, 8'h10, r, r2);
    e = mk(16'h0, 16'h1002, 3'd2, 4'h1, 1'b0, 1'b0);
    e.ce = 1'b0;
    e.imm = 1'b1;
    e.opd = r;
    run(16'h1000, e);
    pk(16'h1000, {4'h2, 4'($urandom)}, r, r2);
    run(16'h1000, mk({8'h00, r}, 16'h1002, 3'd2, 4'h2, 1'b0, 1'b0));
    for (k = 0; k < 16; k++)
    begin
      pk(16'h1000, {4'h3, 4'(k)}, r, r2);
      e = mk({r, r2}, 16'h1003, 3'd3, 4'h3, 1'b0, 1'b0);
      e.ill = (k >= 10);
      run(16'h1000, e);
    end
    pk(16'h1000, 8'h40, r, r2);
    run(16'h1000, mk(16'h00ff, 16'h1001, 3'd1, 4'h4, 1'b0, 1'b0));
    pk(16'h1000, 8'h50, 8'hff, r2);
    run(16'h1000, mk(16'h01fe, 16'h1002, 3'd2, 4'h5, 1'b0, 1'b0));
    pk(16'h1000, 8'h60, r, r2);
    run(16'h1000, mk({r, r2} + 16'h00ff, 16'h1003, 3'd3, 4'h6, 1'b0, 1'b0));
    for (k = 0; k < 2; k++)
    begin
      pk(16'h1000, 8'h70, k ? 8'h7f : 8'h80, r2);
      run(16'h1000, mk(k ? 16'h1081 : 16'h0f82, 16'h1002, 3'd2, 4'h7, 1'b0, 1'b0));
    end
    pk(16'h1000, 8'h90, 8'h55, r);
    run(16'h1000, mk({8'h00, yv} + {8'h00, r}, 16'h1003, 3'd3, 4'h5, 1'b1, 1'b0));
    pk(16'h0040, r, r, r2);
    pk(16'h0046, 8'h80, r, r2);
    pk(16'h1000, 8'h92, 8'h20, 8'h40);
    run(16'h1000, mk({8'h00, r}, 16'h1003, 3'd3, 4'h2, 1'b0, 1'b1));
    pk(16'h1000, 8'h92, 8'h30, 8'h41);
    run(16'h1000, mk({r, r2}, 16'h1003, 3'd3, 4'h3, 1'b0, 1'b1));
    pk(16'h1000, 8'h92, 8'h50, 8'h40);
    run(16'h1000, mk({8'h00, r} + 16'h00ff, 16'h1003, 3'd3, 4'h5, 1'b0, 1'b1));
    pk(16'h1000, 8'h92, 8'h60, 8'h41);
    run(16'h1000, mk({r, r2} + 16'h00ff, 16'h1003, 3'd3, 4'h6, 1'b0, 1'b1));
    pk(16'h1000, 8'h92, 8'h70, 8'h46);
    run(16'h1000, mk(16'h0f83, 16'h1003, 3'd3, 4'h7, 1'b0, 1'b1));
    pk(16'h1000, 8'h91, 8'h50, 8'h40);
    run(16'h1000, mk({8'h00, r} + {8'h00, yv}, 16'h1003, 3'd3, 4'h5, 1'b1, 1'b1));
    pk(16'h1000, 8'h91, 8'h20, r);
    e = mk({8'h00, r}, 16'h1003, 3'd3, 4'h2, 1'b0, 1'b0);
    e.pfx = 1'b1;
    run(16'h1000, e);
    e.ill = 1'b1;
    pk(16'h1000, 8'h91, 8'h90, r);
    run(16'h1000, e);
    for (k = 8; k < 16; k++)
    begin
      pk(16'h1000, {4'(k), 4'($urandom)}, 8'h90, r);
      run(16'h1000, e);
    end
    end_of_test;
  end
endmodule // test_cpu_addressing_mode_decoder

/* hw/cam_addr_decoder.v */
// Operation
// RULE1 - Implied-operand instructions are one byte
// RULE2 - Literal operand: one byte after opcode
// RULE3 - Short absolute: one address byte, page zero
// RULE4 - Long absolute: two address bytes, full space
// RULE5 - Indexed address is index plus offset
// RULE6 - Zero-offset indexed: no byte, page zero
// RULE7 - Short indexed: byte offset, carry bit 8
// RULE8 - Long indexed: word offset plus index
// RULE9 - Pointer modes read pointer at given byte
// RULE10 - Short pointer: byte pointer, page zero
// RULE11 - Long pointer: word pointer, two bytes read
// RULE12 - Pointer plus index, unsigned sum
// RULE13 - Only load/compare/logic/arith take long forms
// RULE14 - Other memory groups take short forms only
// RULE15 - Relative: signed offset, direct or indirect
// RULE16 - 63 instructions in 13 groups
// RULE17 - Instructions span one to four bytes
// RULE18 - Three prebytes extend opcode space
// RULE19 - Prebyte 90 swaps first index for second
// RULE20 - Prebyte 92 selects pointer forms
// RULE21 - Prebyte 91 pointer-indexed uses second index
// RULE22 - Trap, wait, halt are single-byte
// RULE23 - Undefined code resets; odd combination does not
// RULE24 - Offset added to next-instruction address
// RULE25 - Addresses are 16-bit, carry kept
`timescale 1ns/1ps
`include "cam_addr_map.vh"

module cam_addr_decoder
(
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        fetchStart,
  input  wire [15:0] pcStart,
  input  wire [7:0]  idxX,
  input  wire [7:0]  idxY,
  input  wire [7:0]  memRdata,
  input  wire        memAck,
  output reg         memRd,
  output reg  [15:0] memAddr,
  output reg         busy,
  output reg         done,
  output reg  [7:0]  opcode,
  output reg  [3:0]  modeOut,
  output reg  [3:0]  opGroup,
  output reg         useSecondIndex,
  output reg         viaPointer,
  output reg         immValid,
  output reg  [7:0]  operand,
  output reg  [15:0] effAddr,
  output reg  [15:0] nextPc,
  output reg  [2:0]  instrLen,
  output reg         swInterrupt,
  output reg         waitEntry,
  output reg         haltEntry,
  output reg         prefixIgnored,
  output reg         illegalReset
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_OP   = 3'd1;
  localparam [2:0] ST_B1   = 3'd2;
  localparam [2:0] ST_B2   = 3'd3;
  localparam [2:0] ST_P1   = 3'd4;
  localparam [2:0] ST_P2   = 3'd5;
  localparam [2:0] ST_CALC = 3'd6;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Mode nibbles above the last defined one are not opcodes
  function isDefined;
    input [3:0] mode;
    input [3:0] op;
    begin
      isDefined = 1'b1;
      if (mode > `CAM_MODE_LAST)
        isDefined = 1'b0; // see RULE23
      else if (((mode == `CAM_MODE_DIR_L) || (mode == `CAM_MODE_IDX_L))
               && (op >= `CAM_OP_LONG_LIMIT))
        isDefined = 1'b0; // see RULE13 see RULE14
    end
  endfunction

  // Functional group of an instruction, 0 to 12
  function [3:0] groupOf;
    input [3:0] mode;
    input [3:0] op;
    begin
      groupOf = 4'd0;
      if (mode == `CAM_MODE_REL)
        groupOf = (op == 4'h0) ? 4'd9 : 4'd10;
      else if (mode == `CAM_MODE_INH)
      begin
        case (op)
          4'h0: groupOf = 4'd9;
          4'h1: groupOf = 4'd11;
          4'h2: groupOf = 4'd11;
          4'h3: groupOf = 4'd11;
          4'h4: groupOf = 4'd9;
          4'h5: groupOf = 4'd11;
          4'h6: groupOf = 4'd12;
          4'h7: groupOf = 4'd12;
          4'h8: groupOf = 4'd12;
          4'h9: groupOf = 4'd12;
          4'ha: groupOf = 4'd1;
          4'hb: groupOf = 4'd1;
          4'hc: groupOf = 4'd7;
          4'hd: groupOf = 4'd0;
          4'he: groupOf = 4'd8;
          default: groupOf = 4'd2;
        endcase
      end
      else
      begin
        case (op)
          4'h0: groupOf = 4'd0;
          4'h1: groupOf = 4'd3;
          4'h2: groupOf = 4'd3;
          4'h3: groupOf = 4'd4;
          4'h4: groupOf = 4'd4;
          4'h5: groupOf = 4'd4;
          4'h6: groupOf = 4'd7;
          4'h7: groupOf = 4'd7;
          4'h8: groupOf = 4'd7;
          4'h9: groupOf = 4'd7;
          4'ha: groupOf = 4'd0;
          4'hb: groupOf = 4'd2;
          4'hc: groupOf = 4'd5;
          4'hd: groupOf = 4'd6;
          4'he: groupOf = 4'd8;
          default: groupOf = 4'd9;
        endcase
      end
    end
  endfunction

  // Bytes after the opcode; pointer forms carry only the pointer address
  function [1:0] bytesAfter;
    input [3:0] mode;
    input       ptr;
    begin
      case (mode)
        `CAM_MODE_INH:   bytesAfter = 2'd0; // see RULE1
        `CAM_MODE_IMM:   bytesAfter = 2'd1; // see RULE2
        `CAM_MODE_DIR_S: bytesAfter = 2'd1; // see RULE3 see RULE10
        `CAM_MODE_DIR_L: bytesAfter = ptr ? 2'd1 : 2'd2; // see RULE4 see RULE11
        `CAM_MODE_IDX0:  bytesAfter = 2'd0; // see RULE6
        `CAM_MODE_IDX_S: bytesAfter = 2'd1; // see RULE7
        `CAM_MODE_IDX_L: bytesAfter = ptr ? 2'd1 : 2'd2; // see RULE8 see RULE12
        `CAM_MODE_REL:   bytesAfter = 2'd1; // see RULE15
        default:         bytesAfter = 2'd0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2:0]  state_reg;
  reg [15:0] pc_reg;
  reg [7:0]  prefix_reg;
  reg        havePrefix_reg;
  reg [7:0]  byte1_reg;
  reg [7:0]  byte2_reg;
  reg [7:0]  ptrHi_reg;
  reg [7:0]  ptrLo_reg;
  reg [1:0]  need_reg;
  reg        ptrWord_reg;
  reg [7:0]  idxSel_reg;

  // Prefix handling on the opcode just fetched
  wire [3:0] fetchMode = memRdata[`CAM_MODE_MSB:`CAM_MODE_LSB];
  wire [3:0] fetchOp   = memRdata[`CAM_OP_MSB:`CAM_OP_LSB];
  wire isPrebyte = (memRdata == `CAM_PRE_SECOND_INDEX) ||
                   (memRdata == `CAM_PRE_POINTER_SECOND) ||
                   (memRdata == `CAM_PRE_POINTER); // see RULE18

  wire modeIndexed = (fetchMode == `CAM_MODE_IDX_S) || (fetchMode == `CAM_MODE_IDX_L);
  wire modeDirect  = (fetchMode == `CAM_MODE_DIR_S) || (fetchMode == `CAM_MODE_DIR_L);
  wire modeRel     = (fetchMode == `CAM_MODE_REL);

  // Which prefixes are authorised for this mode
  reg pfxOk;
  reg pfxPtr;
  reg pfxY;
  always @*
  begin
    pfxOk  = 1'b1;
    pfxPtr = 1'b0;
    pfxY   = 1'b0;
    if (havePrefix_reg)
    begin
      case (prefix_reg)
        `CAM_PRE_SECOND_INDEX:
        begin
          pfxOk = !modeRel; // see RULE19
          pfxY  = pfxOk;
        end
        `CAM_PRE_POINTER:
        begin
          // Zero-offset indexed has no pointer variant
          pfxOk  = modeDirect || modeRel || modeIndexed;
          pfxPtr = pfxOk; // see RULE20
        end
        `CAM_PRE_POINTER_SECOND:
        begin
          pfxOk  = modeIndexed;
          pfxPtr = pfxOk; // see RULE21
          pfxY   = pfxOk;
        end
        default: pfxOk = 1'b1;
      endcase
    end
  end

  // Sign-extended relative offset, from the byte or from memory
  wire [7:0]  relOff   = viaPointer ? ptrLo_reg : byte1_reg;
  wire [15:0] relTarget = pc_reg + {{8{relOff[7]}}, relOff}; // see RULE24

  // Effective address for every memory mode, kept 16 bits wide
  reg [15:0] eaCalc;
  always @*
  begin
    eaCalc = `CAM_ADDR_RST;
    case (modeOut)
      `CAM_MODE_DIR_S:
        eaCalc = viaPointer ? {8'h00, ptrLo_reg} : {8'h00, byte1_reg}; // see RULE10
      `CAM_MODE_DIR_L:
        eaCalc = viaPointer ? {ptrHi_reg, ptrLo_reg} : {byte1_reg, byte2_reg};
      `CAM_MODE_IDX0:
        eaCalc = {8'h00, idxSel_reg}; // see RULE6
      `CAM_MODE_IDX_S:
        eaCalc = viaPointer ? ({8'h00, ptrLo_reg} + {8'h00, idxSel_reg})
                            : ({8'h00, byte1_reg} + {8'h00, idxSel_reg}); // see RULE7 see RULE25
      `CAM_MODE_IDX_L: // see RULE5 see RULE12
        eaCalc = viaPointer ? ({ptrHi_reg, ptrLo_reg} + {8'h00, idxSel_reg})
                            : ({byte1_reg, byte2_reg} + {8'h00, idxSel_reg});
      `CAM_MODE_REL:
        eaCalc = relTarget; // see RULE15
      default:
        eaCalc = `CAM_ADDR_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  // One read outstanding at a time; memRd stays up until memAck
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg      <= ST_IDLE;
      pc_reg         <= `CAM_ADDR_RST;
      prefix_reg     <= `CAM_BYTE_RST;
      havePrefix_reg <= 1'b0;
      byte1_reg      <= `CAM_BYTE_RST;
      byte2_reg      <= `CAM_BYTE_RST;
      ptrHi_reg      <= `CAM_BYTE_RST;
      ptrLo_reg      <= `CAM_BYTE_RST;
      need_reg       <= 2'd0;
      ptrWord_reg    <= 1'b0;
      idxSel_reg     <= `CAM_BYTE_RST;
      memRd          <= 1'b0;
      memAddr        <= `CAM_ADDR_RST;
      busy           <= 1'b0;
      done           <= 1'b0;
      opcode         <= `CAM_BYTE_RST;
      modeOut        <= `CAM_MODE_INH;
      opGroup        <= 4'd0;
      useSecondIndex <= 1'b0;
      viaPointer     <= 1'b0;
      immValid       <= 1'b0;
      operand        <= `CAM_BYTE_RST;
      effAddr        <= `CAM_ADDR_RST;
      nextPc         <= `CAM_ADDR_RST;
      instrLen       <= 3'd0;
      swInterrupt    <= 1'b0;
      waitEntry      <= 1'b0;
      haltEntry      <= 1'b0;
      prefixIgnored  <= 1'b0;
      illegalReset   <= 1'b0;
    end
    else
    begin
      // Result strobes last one cycle
      done         <= 1'b0;
      swInterrupt  <= 1'b0;
      waitEntry    <= 1'b0;
      haltEntry    <= 1'b0;
      illegalReset <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (fetchStart)
          begin
            pc_reg         <= pcStart;
            memAddr        <= pcStart;
            memRd          <= 1'b1;
            busy           <= 1'b1;
            havePrefix_reg <= 1'b0;
            instrLen       <= 3'd1;
            state_reg      <= ST_OP;
          end
        end
        ST_OP:
        begin
          if (memAck)
          begin
            pc_reg <= pc_reg + 16'h0001;
            if (isPrebyte && !havePrefix_reg)
            begin
              // Prebyte: remember it and fetch the real opcode
              prefix_reg     <= memRdata;
              havePrefix_reg <= 1'b1;
              instrLen       <= 3'd2; // see RULE17
              memAddr        <= pc_reg + 16'h0001;
            end
            else if (isPrebyte || !isDefined(fetchMode, fetchOp))
            begin
              // Undefined code: ask for a system reset and stop
              memRd        <= 1'b0;
              busy         <= 1'b0;
              illegalReset <= 1'b1; // see RULE23
              state_reg    <= ST_IDLE;
            end
            else
            begin
              opcode         <= memRdata;
              modeOut        <= fetchMode;
              opGroup        <= groupOf(fetchMode, fetchOp); // see RULE16
              useSecondIndex <= pfxY;
              viaPointer     <= pfxPtr;
              prefixIgnored  <= !pfxOk; // see RULE23
              idxSel_reg     <= pfxY ? idxY : idxX; // see RULE19 see RULE21
              ptrWord_reg    <= (fetchMode == `CAM_MODE_DIR_L) ||
                                (fetchMode == `CAM_MODE_IDX_L); // see RULE11
              need_reg       <= bytesAfter(fetchMode, pfxPtr);
              if (bytesAfter(fetchMode, pfxPtr) == 2'd0)
              begin
                memRd     <= 1'b0;
                state_reg <= ST_CALC;
              end
              else
              begin
                memAddr   <= pc_reg + 16'h0001;
                state_reg <= ST_B1;
              end
            end
          end
        end
        ST_B1:
        begin
          if (memAck)
          begin
            byte1_reg <= memRdata;
            pc_reg    <= pc_reg + 16'h0001;
            instrLen  <= instrLen + 3'd1;
            if (need_reg == 2'd2)
            begin
              memAddr   <= pc_reg + 16'h0001;
              state_reg <= ST_B2;
            end
            else if (viaPointer)
            begin
              // Byte is the pointer address in page zero
              memAddr   <= {8'h00, memRdata}; // see RULE9
              state_reg <= ST_P1;
            end
            else
            begin
              memRd     <= 1'b0;
              state_reg <= ST_CALC;
            end
          end
        end
        ST_B2:
        begin
          if (memAck)
          begin
            byte2_reg <= memRdata;
            pc_reg    <= pc_reg + 16'h0001;
            instrLen  <= instrLen + 3'd1;
            memRd     <= 1'b0;
            state_reg <= ST_CALC;
          end
        end
        ST_P1:
        begin
          if (memAck)
          begin
            if (ptrWord_reg)
            begin
              // Word pointer: high byte first, low byte next address
              ptrHi_reg <= memRdata;
              memAddr   <= memAddr + 16'h0001;
              state_reg <= ST_P2;
            end
            else
            begin
              ptrHi_reg <= `CAM_BYTE_RST;
              ptrLo_reg <= memRdata; // see RULE10
              memRd     <= 1'b0;
              state_reg <= ST_CALC;
            end
          end
        end
        ST_P2:
        begin
          if (memAck)
          begin
            ptrLo_reg <= memRdata;
            memRd     <= 1'b0;
            state_reg <= ST_CALC;
          end
        end
        ST_CALC:
        begin
          // pc_reg already points at the next instruction
          effAddr   <= eaCalc;
          nextPc    <= pc_reg;
          immValid  <= (modeOut == `CAM_MODE_IMM); // see RULE2
          operand   <= byte1_reg;
          busy      <= 1'b0;
          done      <= 1'b1;
          state_reg <= ST_IDLE;
          if (modeOut == `CAM_MODE_INH)
          begin
            swInterrupt <= (opcode[`CAM_OP_MSB:`CAM_OP_LSB] == `CAM_INH_TRAP); // see RULE22
            waitEntry   <= (opcode[`CAM_OP_MSB:`CAM_OP_LSB] == `CAM_INH_WAIT);
            haltEntry   <= (opcode[`CAM_OP_MSB:`CAM_OP_LSB] == `CAM_INH_HALT);
          end
        end
        default:
        begin
          memRd     <= 1'b0;
          busy      <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // cam_addr_decoder

/* hw/cam_addr_map.vh */
`ifndef CAM_ADDR_MAP_VH
`define CAM_ADDR_MAP_VH

// ----------------------------------------------------------------
// Prebyte codes
// ----------------------------------------------------------------
`define CAM_PRE_SECOND_INDEX   8'h90
`define CAM_PRE_POINTER_SECOND 8'h91
`define CAM_PRE_POINTER        8'h92

// ----------------------------------------------------------------
// Opcode fields: high nibble is the mode, low nibble the operation
// ----------------------------------------------------------------
`define CAM_MODE_MSB  7
`define CAM_MODE_LSB  4
`define CAM_OP_MSB    3
`define CAM_OP_LSB    0

// Mode codes
`define CAM_MODE_INH     4'h0
`define CAM_MODE_IMM     4'h1
`define CAM_MODE_DIR_S   4'h2
`define CAM_MODE_DIR_L   4'h3
`define CAM_MODE_IDX0    4'h4
`define CAM_MODE_IDX_S   4'h5
`define CAM_MODE_IDX_L   4'h6
`define CAM_MODE_REL     4'h7
`define CAM_MODE_LAST    4'h7

// Operation codes below this value accept long forms
`define CAM_OP_LONG_LIMIT 4'ha

// Inherent operations with side effects
`define CAM_INH_TRAP  4'h1
`define CAM_INH_WAIT  4'h2
`define CAM_INH_HALT  4'h3

// Instruction set size
`define CAM_INSTR_COUNT 63
`define CAM_GROUP_COUNT 13

// Reset values
`define CAM_ADDR_RST 16'h0000
`define CAM_BYTE_RST 8'h00

`endif
